// ### src/ecap_channel.sv
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: Capture mode timestamps edges on the event input against the internal counter.
// R2: One mode bit in the second control register selects capture or pulse mode.
// R3: In pulse mode the counter counts only upward as the waveform time base.
// R4: In pulse mode first register is period, second is compare.
// R5: In pulse mode third and fourth registers shadow period and compare.
// R6: The same four registers serve both modes, meaning set by the mode bit.
// R7: Counter has a sync input and sync output for chaining timing modules.
// R8: Capture, pulse and counter events are flagged and merged into one interrupt.
// R9: Channel runs on the system clock, gated by a system-control enable bit.
// R10: Event source holds capture pulses at least two system clock cycles.
// R11: Each qualifying edge latches the counter into the next register and flags it.
module ecap_channel
    import ecap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic capture_event_input,
    input wire logic counter_sync_input,
    output logic counter_sync_output,
    output logic aux_pulse_output,
    output logic channel_interrupt_request
);
    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic req_w;
    logic wr_w;
    logic [7:0] ofs_w;
    logic hit_w;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic [31:0] wmask_w;
    assign req_w = wb_cyc_i & wb_stb_i & ~ack_reg;
    // Writes land at the edge that samples ack, as a classic master expects;
    // an acked request always hit, so the address check is not repeated here
    assign wr_w = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    assign ofs_w = wb_adr_i[7:0];
    assign hit_w = (wb_adr_i[31:8] == 24'h000000) && (ofs_w[1:0] == 2'h0) && (ofs_w <= ECAP_OFS_SYSCTL);
    assign wmask_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0] ctrl1_reg;
    logic [31:0] ctrl2_reg;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [31:0] phase_reg;
    logic [31:0] cap_reg [4];
    logic [ECAP_NFLAGS-1:0] flag_reg;
    logic [ECAP_NFLAGS-1:0] mask_reg;
    logic [ECAP_NFLAGS-1:0] evt_w;
    logic clken_reg;
    logic [1:0] idx_reg;
    logic pulse_reg;
    logic pwm_mode_w;
    logic run_w;
    logic sync_w;
    logic counter_sync_input_w;
    logic counter_sync_input_d_reg;
    logic cap_hit_w;
    logic prd_hit_w;
    logic cmp_hit_w;
    logic ovf_w;
    logic [3:0] cap_evt_w;
    ecap_seq_type seq_w;
    ecap_evt_if cap_if ();
    ecap_evt_if syn_if ();
    // Capture pin and sync pin each pass two flops before use
    ecap_edge u_cap (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(capture_event_input),
        .evt(cap_if)
    );
    ecap_edge u_syn (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(counter_sync_input),
        .evt(syn_if)
    );
    assign pwm_mode_w = ctrl2_reg[ECAP_BIT_MODE]; // R2 R6
    assign run_w = clken_reg & ctrl2_reg[ECAP_BIT_RUN]; // R9
    assign counter_sync_input_w = syn_if.rise & ctrl2_reg[ECAP_BIT_SYNCI_EN]; // R7
    assign sync_w = counter_sync_input_w | (wr_w && ofs_w == ECAP_OFS_CTRL2 && wb_sel_i[0] && wb_dat_i[ECAP_BIT_SWSYNC]);
    assign prd_hit_w = run_w & pwm_mode_w & (count_reg == cap_reg[0]);
    assign cmp_hit_w = run_w & pwm_mode_w & (count_reg == cap_reg[1]);
    assign ovf_w = run_w & ~pwm_mode_w & (count_reg == 32'hFFFF_FFFF);
    // One-hot register select for the event now in line
    assign seq_w = ecap_seq_type'(4'h1 << idx_reg);
    assign cap_hit_w = run_w & ~pwm_mode_w & (ctrl1_reg[ECAP_BIT_POL0 + idx_reg] ? cap_if.fall : cap_if.rise); // R1
    assign cap_evt_w = cap_hit_w ? seq_w : 4'h0;
    assign evt_w = {cmp_hit_w, prd_hit_w, ovf_w, cap_evt_w}; // R8
    // Counter: loads phase on sync, wraps on period in pulse mode
    always_comb begin
        count_next = count_reg;
        if (sync_w) begin
            count_next = phase_reg; // R7
        end else if (run_w) begin
            count_next = prd_hit_w ? ECAP_RST_WORD : count_reg + 32'h0000_0001; // R3
        end
    end
    // Sync output: sync input delayed one cycle, or a period match
    assign counter_sync_output = ctrl2_reg[ECAP_BIT_SYNCO_SEL] ? prd_hit_w : counter_sync_input_d_reg; // R7
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= ECAP_RST_WORD;
            counter_sync_input_d_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            counter_sync_input_d_reg <= counter_sync_input_w;
        end
    end
    // Capture sequencing; stamps the counter value of the detect cycle
    always_ff @(posedge clk_sys) begin
        if (rst || pwm_mode_w) begin
            idx_reg <= ECAP_RST_IDX;
        end else if (cap_hit_w) begin
            idx_reg <= idx_reg + 2'h1; // R11
        end
    end
    // Pulse output: high from period reload until compare match
    always_ff @(posedge clk_sys) begin
        if (rst || !pwm_mode_w) begin
            pulse_reg <= 1'b0;
        end else if (cmp_hit_w) begin
            pulse_reg <= 1'b0;
        end else if (prd_hit_w) begin
            pulse_reg <= 1'b1;
        end
    end
    assign aux_pulse_output = pulse_reg ^ ctrl2_reg[ECAP_BIT_OUT_POL];
    // Control and system registers; software sync bit is self-clearing
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl1_reg <= ECAP_RST_CTRL;
            ctrl2_reg <= ECAP_RST_CTRL;
            phase_reg <= ECAP_RST_WORD;
            mask_reg <= '0;
            clken_reg <= ECAP_RST_CLKEN;
        end else if (wr_w) begin
            case (ofs_w)
                ECAP_OFS_CTRL1: ctrl1_reg <= (ctrl1_reg & ~wmask_w) | (wb_dat_i & wmask_w & 32'h0000_000F);
                ECAP_OFS_CTRL2: ctrl2_reg <= (ctrl2_reg & ~wmask_w) | (wb_dat_i & wmask_w & 32'h0000_001F);
                ECAP_OFS_PHASE: phase_reg <= (phase_reg & ~wmask_w) | (wb_dat_i & wmask_w);
                ECAP_OFS_MASK: if (wb_sel_i[0]) mask_reg <= wb_dat_i[ECAP_NFLAGS-1:0];
                ECAP_OFS_SYSCTL: if (wb_sel_i[0]) clken_reg <= wb_dat_i[0]; // R9
                default: ;
            endcase
        end
    end
    // Four shared registers: stamps in capture mode, period/compare with
    // shadows in pulse mode. Software writes to the third and fourth land in
    // the shadows, which reach the active pair at the period boundary.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_cap
            logic [7:0] my_ofs;
            logic wr_hit;
            assign my_ofs = ECAP_OFS_SLOT1 + 8'(4 * i);
            assign wr_hit = wr_w && (ofs_w == my_ofs);
            if (i < 2) begin : g_active
                // Active pair; a write that meets a period match loses to the reload
                always_ff @(posedge clk_sys) begin
                    if (rst) begin
                        cap_reg[i] <= ECAP_RST_WORD;
                    end else if (cap_evt_w[i]) begin
                        cap_reg[i] <= count_reg; // R1 R11
                    end else if (prd_hit_w) begin
                        cap_reg[i] <= cap_reg[i + 2]; // R4 R5
                    end else if (wr_hit) begin
                        cap_reg[i] <= (cap_reg[i] & ~wmask_w) | (wb_dat_i & wmask_w); // R4
                    end
                end
            end else begin : g_shadow
                // Shadow pair; written by software and by capture stamps, never by the period logic
                always_ff @(posedge clk_sys) begin
                    if (rst) begin
                        cap_reg[i] <= ECAP_RST_WORD;
                    end else if (cap_evt_w[i]) begin
                        cap_reg[i] <= count_reg; // R1 R11
                    end else if (wr_hit) begin
                        cap_reg[i] <= (cap_reg[i] & ~wmask_w) | (wb_dat_i & wmask_w); // R5
                    end
                end
            end
        end
    endgenerate
    // Sticky flags: set wins over write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_reg <= '0;
        end else if (wr_w && ofs_w == ECAP_OFS_FLAG && wb_sel_i[0]) begin
            flag_reg <= (flag_reg & ~wb_dat_i[ECAP_NFLAGS-1:0]) | evt_w; // R8
        end else begin
            flag_reg <= flag_reg | evt_w; // R8 R11
        end
    end
    assign channel_interrupt_request = |(flag_reg & mask_reg); // R8
    // Read mux
    always_comb begin
        rdat_next = 32'h0000_0000;
        case (ofs_w)
            ECAP_OFS_CTRL1: rdat_next = ctrl1_reg;
            ECAP_OFS_CTRL2: rdat_next = ctrl2_reg;
            ECAP_OFS_COUNT: rdat_next = count_reg;
            ECAP_OFS_PHASE: rdat_next = phase_reg;
            ECAP_OFS_SLOT1: rdat_next = cap_reg[0];
            ECAP_OFS_SLOT2: rdat_next = cap_reg[1];
            ECAP_OFS_SLOT3: rdat_next = cap_reg[2];
            ECAP_OFS_SLOT4: rdat_next = cap_reg[3];
            ECAP_OFS_FLAG: rdat_next = {25'h0, flag_reg};
            ECAP_OFS_MASK: rdat_next = {25'h0, mask_reg};
            ECAP_OFS_SYSCTL: rdat_next = {31'h0, clken_reg};
            default: rdat_next = 32'h0000_0000;
        endcase
    end
    // One-cycle answer; unmapped addresses get err instead of ack
    logic err_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdat_reg <= ECAP_RST_WORD;
        end else begin
            ack_reg <= req_w & hit_w;
            err_reg <= req_w & ~hit_w;
            rdat_reg <= rdat_next;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdat_reg;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_edge_in_cap;
        cap_hit_w;
    endsequence
    AST_CAP_STAMP: assert property (@(posedge clk_sys) disable iff (rst) // R11
        (cap_evt_w[0] && !rst) |=> (cap_reg[0] == $past(count_reg)))
        else $error("first stamp not latched");
    AST_CAP_ADV: assert property (@(posedge clk_sys) disable iff (rst) // R1
        s_edge_in_cap |=> (idx_reg == $past(idx_reg) + 2'h1) || pwm_mode_w)
        else $error("capture index did not advance");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst) // R8
        cap_evt_w[2] |=> flag_reg[2])
        else $error("capture flag not set");
    AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst) // R8
        (cap_evt_w[0] && mask_reg[ECAP_FLG_CEVT0] && !wr_w) |=> channel_interrupt_request)
        else $error("interrupt not raised");
    AST_OVF: assert property (@(posedge clk_sys) disable iff (rst) // R8
        ovf_w |=> flag_reg[ECAP_FLG_OVF])
        else $error("overflow flag not set");
    AST_UPCOUNT: assert property (@(posedge clk_sys) disable iff (rst) // R3
        (pwm_mode_w && run_w && !sync_w && !prd_hit_w) |=> count_reg == $past(count_reg) + 32'h1)
        else $error("pulse counter not counting up");
    AST_SHADOW: assert property (@(posedge clk_sys) disable iff (rst) // R5
        (prd_hit_w && !wr_w) |=> (cap_reg[0] == $past(cap_reg[2])) && (cap_reg[1] == $past(cap_reg[3])))
        else $error("shadow not transferred");
    AST_SYNC_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // R7
        counter_sync_input_w |=> count_reg == $past(phase_reg))
        else $error("sync did not load phase");
    AST_GATE: assert property (@(posedge clk_sys) disable iff (rst) // R9
        (!clken_reg && !sync_w) |=> $stable(count_reg))
        else $error("counter ran with clock gated");
    AST_MODE: assert property (@(posedge clk_sys) disable iff (rst) // R2
        !pwm_mode_w |=> (aux_pulse_output == ctrl2_reg[ECAP_BIT_OUT_POL]))
        else $error("pulse output active in capture mode");
    AST_IDX_PWM: assert property (@(posedge clk_sys) disable iff (rst) // R2
        pwm_mode_w |=> (idx_reg == ECAP_RST_IDX))
        else $error("capture index not held in pulse mode");
    AST_SYNC_OUT: assert property (@(posedge clk_sys) disable iff (rst) // R7
        (counter_sync_input_w && !ctrl2_reg[ECAP_BIT_SYNCO_SEL]) |=> (counter_sync_output || ctrl2_reg[ECAP_BIT_SYNCO_SEL]))
        else $error("sync input not relayed");
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (rst) // R3
        (run_w && prd_hit_w && !sync_w) |=> (count_reg == ECAP_RST_WORD))
        else $error("counter did not wrap at period");
    // Pulse steps: a period match starts the high phase, a compare match ends it
    sequence s_period_match;
        prd_hit_w && !cmp_hit_w;
    endsequence
    sequence s_compare_match;
        cmp_hit_w;
    endsequence
    AST_PULSE_HI: assert property (@(posedge clk_sys) disable iff (rst) // R4
        s_period_match |=> pulse_reg)
        else $error("pulse not raised at period match");
    AST_PULSE_LO: assert property (@(posedge clk_sys) disable iff (rst) // R4
        s_compare_match |=> !pulse_reg)
        else $error("pulse not lowered at compare match");
    AST_CAP_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R11
        (!pwm_mode_w && !cap_evt_w[1] && !wr_w) |=> $stable(cap_reg[1]))
        else $error("stamp changed without an event");
    AST_SHADOW_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R5
        (pwm_mode_w && !wr_w) |=> ($stable(cap_reg[2]) && $stable(cap_reg[3])))
        else $error("shadow changed without a write");
endmodule : ecap_channel
`default_nettype wire

// ### common/ecap_pkg.sv
package ecap_pkg;
    // ****************************************************************
    // Register map (byte offsets, byte offset = 4 x word index)
    // ****************************************************************
    localparam logic [7:0] ECAP_OFS_CTRL1 = 8'h00;
    localparam logic [7:0] ECAP_OFS_CTRL2 = 8'h04;
    localparam logic [7:0] ECAP_OFS_COUNT = 8'h08;
    localparam logic [7:0] ECAP_OFS_PHASE = 8'h0C;
    localparam logic [7:0] ECAP_OFS_SLOT1 = 8'h10;
    localparam logic [7:0] ECAP_OFS_SLOT2 = 8'h14;
    localparam logic [7:0] ECAP_OFS_SLOT3 = 8'h18;
    localparam logic [7:0] ECAP_OFS_SLOT4 = 8'h1C;
    localparam logic [7:0] ECAP_OFS_FLAG = 8'h20;
    localparam logic [7:0] ECAP_OFS_MASK = 8'h24;
    localparam logic [7:0] ECAP_OFS_SYSCTL = 8'h28;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    // Control 1: edge polarity per capture event (1 = falling)
    localparam int ECAP_BIT_POL0 = 0;
    // Control 2 fields
    localparam int ECAP_BIT_RUN = 0;
    localparam int ECAP_BIT_SYNCI_EN = 1;
    localparam int ECAP_BIT_SYNCO_SEL = 2;
    localparam int ECAP_BIT_MODE = 3;
    localparam int ECAP_BIT_OUT_POL = 4;
    localparam int ECAP_BIT_SWSYNC = 5;
    // Flag bits
    localparam int ECAP_FLG_CEVT0 = 0;
    localparam int ECAP_FLG_OVF = 4;
    localparam int ECAP_FLG_PRD = 5;
    localparam int ECAP_FLG_CMP = 6;
    localparam int ECAP_NFLAGS = 7;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] ECAP_RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] ECAP_RST_WORD = 32'h0000_0000;
    localparam logic ECAP_RST_CLKEN = 1'b0;
    localparam logic [1:0] ECAP_RST_IDX = 2'h0;
    // Capture event sequence
    typedef enum logic [3:0] {
        ECAP_SEQ_E1 = 4'h1,
        ECAP_SEQ_E2 = 4'h2,
        ECAP_SEQ_E3 = 4'h4,
        ECAP_SEQ_E4 = 4'h8
    } ecap_seq_type;
endpackage : ecap_pkg

// ### common/ecap_evt_if.sv
`timescale 1ns/100ps
`default_nettype none
// Capture event rise and fall strobes passed from edge detector to the core
interface ecap_evt_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface : ecap_evt_if
`default_nettype wire

// ### src/ecap_sync2.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser; first stage feeds only the second
module ecap_sync2 (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1_reg;
    // Reset to low so no spurious edge follows reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_reg <= din;
            dout <= s1_reg;
        end
    end
endmodule : ecap_sync2

// ### src/ecap_edge.sv
`timescale 1ns/100ps
`default_nettype none
// Synchronise a pin and report its edges as one-cycle strobes
module ecap_edge (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin,
    ecap_evt_if.src evt
);
    logic sync_w;
    logic prev_reg;
    ecap_sync2 u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(pin),
        .dout(sync_w)
    );
    // Edge memory reads only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sync_w;
        end
    end
    assign evt.rise = sync_w & ~prev_reg;
    assign evt.fall = ~sync_w & prev_reg;
endmodule : ecap_edge

// ### verif/ecap_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Event source and neighbouring timer
// ****************
module ecap_partner (
    input wire logic clk_sys,
    input wire logic fire_evt,
    input wire logic fire_sync,
    output logic evt_pin,
    output logic sync_pin
);
    logic [2:0] hold_reg = 3'h0;
    logic [1:0] sync_reg = 2'h0;
    initial evt_pin = 1'b0;
    // Each level stands at least five cycles; a request inside the hold is dropped, never shortened
    always @(posedge clk_sys) begin
        if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
        else if (fire_evt) begin
            evt_pin <= ~evt_pin;
            hold_reg <= 3'h4;
        end
        if (fire_sync) sync_reg <= 2'h3;
        else if (sync_reg != 2'h0) sync_reg <= sync_reg - 2'h1;
    end
    // Sync pulse is three cycles wide, above the two-cycle minimum
    assign sync_pin = (sync_reg != 2'h0);
endmodule : ecap_partner
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench import ecap_pkg::*;;
    typedef struct packed {logic [7:0] a; logic [31:0] d;} ecap_row_type;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, q, c1;
    logic [3:0] sel = 4'hF;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, err, e;
    logic evt, sync_in, sync_out, aux, irq;
    logic fire_evt = 1'b0, fire_sync = 1'b0;
    logic [31:0] cap [4];
    int err_total = 0;
    int comparisons = 0;
    int so_cnt = 0;
    int t, h, so0;
    ecap_row_type rows [4] = '{'{ECAP_OFS_CTRL1, 32'h0000_000A}, '{ECAP_OFS_PHASE, 32'h1234_5678},
        '{ECAP_OFS_MASK, 32'h0000_007F}, '{ECAP_OFS_SYSCTL, 32'h0000_0001}};

    // ****************
    // Clock, design and partner
    // ****************
    always #20 clk_sys = ~clk_sys;
    ecap_channel ecap_channel_i (.clk_sys(clk_sys), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .wb_err_o(err), .capture_event_input(evt), .counter_sync_input(sync_in),
        .counter_sync_output(sync_out), .aux_pulse_output(aux), .channel_interrupt_request(irq));
    ecap_partner ecap_partner_i (.clk_sys(clk_sys), .fire_evt(fire_evt), .fire_sync(fire_sync),
        .evt_pin(evt), .sync_pin(sync_in));
    // Sync output pulses are one cycle, so counting high cycles counts pulses
    always @(posedge clk_sys) if (sync_out === 1'b1) so_cnt++;

    // Classic single cycle; the extra edge at the end keeps cyc low for a cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= {24'h0, a};
        we <= w;
        wdat <= d;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_sys);
    endtask : wb

    // One request to the partner, ten cycles a call so stamp gaps are known
    task automatic fire(input logic s);
        if (s) fire_sync <= 1'b1;
        else fire_evt <= 1'b1;
        @(posedge clk_sys);
        fire_sync <= 1'b0;
        fire_evt <= 1'b0;
        repeat (9) @(posedge clk_sys);
    endtask : fire

    task automatic rise(output int n);
        logic p;
        p = 1'b1;
        n = 0;
        repeat (3000) begin
            @(posedge clk_sys);
            n++;
            if (aux === 1'b1 && p === 1'b0) break;
            p = aux;
        end
    endtask : rise

    // Counter wraps after the period value and the output falls after the compare value
    task automatic pwm_chk(input int p, input int c);
        rise(t);
        h = 0;
        while (aux === 1'b1 && h < 3000) begin @(posedge clk_sys); h++; end
        rise(t);
        `CHK("pwm high", c + 1, h)
        `CHK("pwm period", p + 1, h + t)
    endtask : pwm_chk

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            wb(rows[i].a, 1'b1, rows[i].d);
            wb(rows[i].a, 1'b0, 32'h0);
            `CHK("read back", rows[i].d, q)
        end
        // Mid-run reset: everything reads zero, counter frozen while its clock is off
        rst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            wb(8'(i * 4), 1'b0, 32'h0);
            `CHK("reset value", ECAP_RST_WORD, q)
        end
        for (int i = 0; i < 4; i++) wb(rows[i].a, 1'b1, rows[i].d);
        wb(8'h2C, 1'b0, 32'h0);
        `CHK("unmapped err", 1'b1, e)
        // Four edges, alternating polarity, ten cycles apart
        wb(ECAP_OFS_CTRL2, 1'b1, 32'h0000_0001);
        repeat (4) fire(1'b0);
        for (int i = 0; i < 4; i++) begin
            wb(ECAP_OFS_SLOT1 + 8'(i * 4), 1'b0, 32'h0);
            cap[i] = q;
        end
        for (int i = 1; i < 4; i++) `CHK("stamp gap", 32'd10, cap[i] - cap[i - 1])
        wb(ECAP_OFS_FLAG, 1'b0, 32'h0);
        `CHK("capture flags", 32'h0000_000F, q)
        `CHK("irq set", 1'b1, irq)
        // Fifth edge wraps to the first register while masked
        wb(ECAP_OFS_FLAG, 1'b1, 32'h0000_000F);
        wb(ECAP_OFS_MASK, 1'b1, 32'h0);
        fire(1'b0);
        wb(ECAP_OFS_FLAG, 1'b0, 32'h0);
        `CHK("wrap flag", 32'h0000_0001, q)
        `CHK("irq masked", 1'b0, irq)
        wb(ECAP_OFS_SLOT1, 1'b0, 32'h0);
        `CHK("wrap stamp", 1'b1, q > cap[3])
        wb(ECAP_OFS_MASK, 1'b1, 32'h0000_0001);
        `CHK("irq unmasked", 1'b1, irq)
        wb(ECAP_OFS_FLAG, 1'b1, 32'h0000_0001);
        `CHK("irq cleared", 1'b0, irq)
        // Sync input loads the phase and is relayed to the sync output
        wb(ECAP_OFS_PHASE, 1'b1, 32'h0000_0100);
        wb(ECAP_OFS_CTRL2, 1'b1, 32'h0000_0003);
        t = so_cnt;
        fire(1'b1);
        wb(ECAP_OFS_COUNT, 1'b0, 32'h0);
        `CHK("sync load", 1'b1, q >= 32'h100 && q < 32'h120)
        `CHK("sync relay", 1, so_cnt - t)
        wb(ECAP_OFS_SYSCTL, 1'b1, 32'h0);
        wb(ECAP_OFS_COUNT, 1'b0, 32'h0);
        c1 = q;
        repeat (5) @(posedge clk_sys);
        wb(ECAP_OFS_COUNT, 1'b0, 32'h0);
        `CHK("gated count", c1, q)
        wb(ECAP_OFS_SYSCTL, 1'b1, 32'h0000_0001);
        // Pulse mode; a software sync puts the counter below the period first
        wb(ECAP_OFS_PHASE, 1'b1, 32'h0);
        wb(ECAP_OFS_CTRL2, 1'b1, 32'h0000_000D);
        for (int i = 0; i < 4; i++) wb(ECAP_OFS_SLOT1 + 8'(i * 4), 1'b1, i[0] ? 32'd5 : 32'd20);
        wb(ECAP_OFS_CTRL2, 1'b1, 32'h0000_002D);
        wb(ECAP_OFS_FLAG, 1'b1, 32'h0000_007F);
        so0 = so_cnt;
        pwm_chk(20, 5);
        `CHK("period sync out", 1'b1, so_cnt > so0)
        wb(ECAP_OFS_FLAG, 1'b0, 32'h0);
        `CHK("pwm flags", 32'h0000_0060, q & 32'h0000_0060)
        // New values go through the shadows and land at a period match
        wb(ECAP_OFS_SLOT3, 1'b1, 32'd40);
        wb(ECAP_OFS_SLOT4, 1'b1, 32'd10);
        rise(t);
        pwm_chk(40, 10);
        wb(ECAP_OFS_SLOT1, 1'b0, 32'h0);
        `CHK("period copied", 32'd40, q)
        wb(ECAP_OFS_SLOT2, 1'b0, 32'h0);
        `CHK("compare copied", 32'd10, q)
        // Back to capture with inverted output; a phase near the top forces an overflow
        wb(ECAP_OFS_PHASE, 1'b1, 32'hFFFF_FFF0);
        wb(ECAP_OFS_CTRL2, 1'b1, 32'h0000_0031);
        wb(ECAP_OFS_FLAG, 1'b1, 32'h0000_007F);
        `CHK("inverted idle", 1'b1, aux)
        repeat (20) @(posedge clk_sys);
        wb(ECAP_OFS_FLAG, 1'b0, 32'h0);
        `CHK("overflow flag", 32'h0000_0010, q)
        summarize();
    end
endmodule : testbench
`default_nettype wire
